//--- sadc_control.sv
`timescale 1ns/10ps
// Operation
// - Done flag low during a conversion, high once finished.
// - Done rising edge at conversion end raises interrupt when global enable is set with mask bit 1, or with irq enable and mask bit 0.
// - External reference select routes reference pin, ignoring internal select.
// - Internal reference code picks supply, 4 V, 3 V or 2 V.
// - Channel global enable low connects no source; firmware sets it first.
// - Channel code picks port A 0-4, port B 1-7, quarter supply, or nothing.
// - Analog pin bit makes pin pure analog, disabling digital function.
// - Conversion clock is cpu clock divided by 16, 8, 1 or 2.
// - Sample pulse lasts 1, 2, 4 or 8 conversion clocks.
// - Resolution code gives 8, 10 or 12 bits.
// - One bit per conversion clock; total sample plus bits plus two.
// - Conversion interval runs from start write until done rises.
module sadc_control (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interrupt
    output logic irq,
    // Analog core
    input wire logic cmpOut,
    output logic [11:0] dacCode,
    output logic samplePulse,
    output logic adcPowerOn,
    output logic [4:0] refSel,
    output logic [13:0] chanConnect,
    output logic [7:0] analogPinA,
    output logic [7:0] analogPinB
);
    logic [3:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic done_q;
    logic [11:0] result_q;
    logic [3:0] cnt_q;
    logic [3:0] bitIdx_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic wait_q;
    logic irq_q;
    logic sample_q;
    logic [4:0] ref_q;
    logic [13:0] chan_q;
    sadc_pkg::sadc_state_e state_q;
    sadc_pkg::sadc_state_e state_d;
    sadc_clk_if ck ();
    logic [11:0] trial;
    // Bus decode
    wire selCtrl = address == sadc_pkg::CTRL_OFS;
    wire selCfg = address == sadc_pkg::CFG_OFS;
    wire selStat = address == sadc_pkg::STAT_OFS;
    wire selMask = address == sadc_pkg::MASK_OFS;
    // Writes land on the answer edge, the only edge at which the master treats them as taken
    wire wrStb = write && ack_q;
    wire rdStb = read && !ack_q;
    wire [31:0] bmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire [31:0] cfgWr = (cfg_q & ~bmask) | (writedata & bmask);
    // Configuration fields
    wire [1:0] shwSel = cfg_q[sadc_pkg::CFG_SHW_LSB +: 2];
    wire [1:0] resSel = cfg_q[sadc_pkg::CFG_RES_LSB +: 2];
    wire extRef = cfg_q[sadc_pkg::CFG_EXTREF_BIT];
    wire [1:0] intRef = cfg_q[sadc_pkg::CFG_INTREF_LSB +: 2];
    wire chan_global_enable = cfg_q[sadc_pkg::CFG_CHAN_GLOBAL_ENABLE_BIT];
    wire [3:0] chanSel = cfg_q[sadc_pkg::CFG_CHAN_LSB +: 4];
    wire enable = ctrl_q[sadc_pkg::CTRL_EN_BIT];
    wire startReq = ctrl_q[sadc_pkg::CTRL_START_BIT];
    wire [3:0] nBits = (resSel[1]) ? sadc_pkg::RES_BITS_12 :
                       (resSel[0]) ? sadc_pkg::RES_BITS_10 : sadc_pkg::RES_BITS_8;
    wire [3:0] shLen = 4'h1 << shwSel;
    wire tick = ck.tick;
    wire finish = tick && (state_q == sadc_pkg::SADC_TAIL)
                  && (cnt_q == sadc_pkg::CONV_OVERHEAD - 4'h1);
    wire launch = (state_q == sadc_pkg::SADC_IDLE) && enable && startReq;
    // Reference one-hot
    wire [4:0] refNext = extRef ? 5'h01 << sadc_pkg::REF_EXT :
                         (intRef == 2'h3) ? 5'h01 << sadc_pkg::REF_SUPPLY :
                         (intRef == 2'h2) ? 5'h01 << sadc_pkg::REF_4V :
                         (intRef == 2'h1) ? 5'h01 << sadc_pkg::REF_3V :
                         5'h01 << sadc_pkg::REF_2V;
    // Channel one-hot: bits 0-4 port A 0-4, 5-11 port B 1-7, 12 quarter supply
    wire [13:0] chanNext = (!chan_global_enable || chanSel > sadc_pkg::CHAN_QUARTER) ? 14'h0000 :
                           14'h0001 << chanSel;
    assign ck.divSel = cfg_q[sadc_pkg::CFG_CLKDIV_LSB +: 2];
    assign ck.run = enable && (state_q != sadc_pkg::SADC_IDLE);
    sadc_clk_div u_div (
        .clock(clock),
        .arst_n(arst_n),
        .ck(ck)
    );
    sadc_sar u_sar (
        .clock(clock),
        .arst_n(arst_n),
        .clear(launch),
        .step(tick && (state_q == sadc_pkg::SADC_BITS)),
        .bitIdx(bitIdx_q),
        .cmpIn(cmpOut),
        .trial(trial)
    );
    // Conversion sequencer: sample, one bit per tick, then two tail periods
    always_comb begin
        state_d = state_q;
        case (state_q)
            sadc_pkg::SADC_IDLE: begin
                if (launch) begin
                    state_d = sadc_pkg::SADC_SAMPLE;
                end
            end
            sadc_pkg::SADC_SAMPLE: begin
                if (tick && cnt_q == shLen - 4'h1) begin
                    state_d = sadc_pkg::SADC_BITS;
                end
            end
            sadc_pkg::SADC_BITS: begin
                if (tick && cnt_q == nBits - 4'h1) begin
                    state_d = sadc_pkg::SADC_TAIL;
                end
            end
            sadc_pkg::SADC_TAIL: begin
                if (finish) begin
                    state_d = sadc_pkg::SADC_IDLE;
                end
            end
            default: state_d = sadc_pkg::SADC_IDLE;
        endcase
        if (!enable) begin
            state_d = sadc_pkg::SADC_IDLE;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= sadc_pkg::SADC_IDLE;
            cnt_q <= 4'h0;
            bitIdx_q <= 4'hB;
        end else begin
            state_q <= state_d;
            if (state_d != state_q) begin
                cnt_q <= 4'h0;
            end else if (tick) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (launch) begin
                bitIdx_q <= 4'hB;
            end else if (tick && state_q == sadc_pkg::SADC_BITS) begin
                bitIdx_q <= bitIdx_q - 4'h1;
            end
        end
    end
    // Done flag, result and start handling
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b1;
            result_q <= 12'h000;
        end else if (launch) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
            // The SAR leaves the next trial bit set below the last decided one; drop it
            result_q <= trial & ~(12'hFFF >> nBits);
        end else if (!enable) begin
            done_q <= 1'b1;
        end
    end
    // Bus registers; start write while busy is dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 4'h0;
            cfg_q <= sadc_pkg::CFG_RESET;
            mask_q <= 2'h0;
        end else begin
            if (wrStb && selCtrl && byteenable[0]) begin
                ctrl_q <= writedata[3:0];
                if (!done_q) begin
                    ctrl_q[sadc_pkg::CTRL_START_BIT] <= startReq;
                end
            end else if (finish || launch) begin
                ctrl_q[sadc_pkg::CTRL_START_BIT] <= 1'b0;
            end
            if (wrStb && selCfg) begin
                cfg_q <= cfgWr;
            end
            if (wrStb && selMask && byteenable[0]) begin
                mask_q <= writedata[1:0];
            end
        end
    end
    // Sticky status: set wins over write-one-to-clear
    wire [1:0] evt = {finish, finish && ctrl_q[sadc_pkg::CTRL_IRQEN_BIT]};
    wire [1:0] w1c = (wrStb && selStat && byteenable[0]) ? writedata[1:0] : 2'h0;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~w1c) | evt;
            irq_q <= |((stat_q & ~w1c | evt) & mask_q) && ctrl_q[sadc_pkg::CTRL_GIE_BIT];
        end
    end
    // Read data and one-wait-state handshake
    wire [31:0] rdMux = selCtrl ? {28'h0, ctrl_q[3:2], startReq, enable} :
                        selCfg ? cfg_q :
                        selStat ? {4'h0, result_q, 13'h0, done_q, stat_q} :
                        selMask ? {30'h0, mask_q} : 32'h00000000;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= (read || write) && !ack_q;
            wait_q <= !((read || write) && !ack_q);
            if (rdStb) begin
                rdata_q <= rdMux;
            end
        end
    end
    // Analog-side outputs registered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sample_q <= 1'b0;
            ref_q <= 5'h00;
            chan_q <= 14'h0000;
        end else begin
            sample_q <= state_d == sadc_pkg::SADC_SAMPLE;
            ref_q <= refNext;
            chan_q <= chanNext;
        end
    end
    assign waitrequest = wait_q;
    assign readdata = rdata_q;
    assign irq = irq_q;
    assign dacCode = trial;
    assign samplePulse = sample_q;
    assign adcPowerOn = ctrl_q[sadc_pkg::CTRL_EN_BIT];
    assign refSel = ref_q;
    assign chanConnect = chan_q;
    assign analogPinA = cfg_q[sadc_pkg::CFG_PA_LSB +: 8];
    assign analogPinB = cfg_q[sadc_pkg::CFG_PB_LSB +: 8];
endmodule

//--- sadc_pkg.sv
package sadc_pkg;
    // Register byte offsets (Avalon word aligned)
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] CFG_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] MASK_OFS = 4'hC;
    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_GIE_BIT = 2;
    localparam int CTRL_IRQEN_BIT = 3;
    // Configuration register fields
    localparam int CFG_CLKDIV_LSB = 0;
    localparam int CFG_SHW_LSB = 2;
    localparam int CFG_RES_LSB = 4;
    localparam int CFG_EXTREF_BIT = 6;
    localparam int CFG_INTREF_LSB = 7;
    localparam int CFG_CHAN_GLOBAL_ENABLE_BIT = 9;
    localparam int CFG_CHAN_LSB = 12;
    localparam int CFG_PA_LSB = 16;
    localparam int CFG_PB_LSB = 24;
    // Status register fields
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_RES_LSB = 16;
    // Reset values
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    // Number of result bits
    localparam logic [3:0] RES_BITS_8 = 4'h8;
    localparam logic [3:0] RES_BITS_10 = 4'hA;
    localparam logic [3:0] RES_BITS_12 = 4'hC;
    // Channel codes
    localparam logic [3:0] CHAN_QUARTER = 4'hC;
    localparam logic [3:0] CHAN_PB_FIRST = 4'h5;
    // Reference select codes (one-hot on refSel output)
    localparam int REF_EXT = 0;
    localparam int REF_SUPPLY = 1;
    localparam int REF_4V = 2;
    localparam int REF_3V = 3;
    localparam int REF_2V = 4;
    // Fixed overhead periods of a conversion
    localparam logic [3:0] CONV_OVERHEAD = 4'h2;
    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SAMPLE,
        SADC_BITS,
        SADC_TAIL
    } sadc_state_e;
endpackage

//--- sadc_clk_if.sv
`timescale 1ns/10ps
interface sadc_clk_if;
    logic [1:0] divSel;
    logic run;
    logic tick;
    modport ctl (output divSel, output run, input tick);
    modport div (input divSel, input run, output tick);
endinterface

//--- sadc_clk_div.sv
`timescale 1ns/10ps
module sadc_clk_div (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Divider control
    sadc_clk_if.div ck
);
    logic [3:0] cnt_q;
    logic [3:0] lim;
    // Divide select: 00 /16, 01 /8, 10 /1, 11 /2
    assign lim = (ck.divSel == 2'h0) ? 4'hF :
                 (ck.divSel == 2'h1) ? 4'h7 :
                 (ck.divSel == 2'h2) ? 4'h0 : 4'h1;
    assign ck.tick = ck.run && (cnt_q >= lim);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
        end else if (!ck.run || ck.tick) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

//--- sadc_sar.sv
`timescale 1ns/10ps
module sadc_sar (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Step control
    input wire logic clear,
    input wire logic step,
    input wire logic [3:0] bitIdx,
    input wire logic cmpIn,
    // Trial word to the analog DAC and settled result
    output logic [11:0] trial
);
    logic [11:0] acc_q;
    logic [11:0] bitMask;
    assign bitMask = 12'h001 << bitIdx;
    assign trial = acc_q;
    // Keep the tested bit when comparator says input is above trial, then set the next
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= 12'h000;
        end else if (clear) begin
            acc_q <= 12'h800;
        end else if (step) begin
            acc_q <= (cmpIn ? acc_q : (acc_q & ~bitMask)) | (bitMask >> 1);
        end
    end
endmodule

//--- sadc_core_model.sv
`timescale 1ns/10ps
module sadc_core_model (
    // Selection and trial word from the block
    input wire logic [13:0] chanConnect,
    input wire logic [11:0] dacCode,
    // Source level in result codes
    input wire logic [11:0] level,
    // Comparator decision
    output logic cmpOut
);
    // Half-code offset keeps the decision off exact ties; no source reads as ground
    assign cmpOut = (chanConnect != 14'h0000) && ({level, 1'b1} > {dacCode, 1'b0});
endmodule

//--- sadc_control_props.sv
`timescale 1ns/10ps
module sadc_control_props (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register bus
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Interrupt and analog side
    input wire logic irq,
    input wire logic samplePulse,
    input wire logic adcPowerOn,
    input wire logic [4:0] refSel,
    input wire logic [13:0] chanConnect
);
    logic [31:0] cfgQ;
    logic [3:0] ctrlQ;
    logic [1:0] maskQ;
    logic [1:0] setQ;
    logic [7:0] highQ;
    wire wrTake = write && !waitrequest;
    wire [31:0] beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                          {8{byteenable[1]}}, {8{byteenable[0]}}};
    wire [31:0] cfgNew = (cfgQ & ~beMask) | (writedata & beMask);
    wire settled = setQ == 2'h3;
    wire [4:0] refExp = cfgQ[6] ? 5'h01 : 5'h02 << (2'h3 - cfgQ[8:7]);
    wire [13:0] chanExp = (cfgQ[9] && cfgQ[15:12] <= 4'hC) ? 14'h0001 << cfgQ[15:12] : 14'h0;
    // Shadow copies follow the byte lanes; control and mask live in lane 0
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfgQ <= 32'h0;
            ctrlQ <= 4'h0;
            maskQ <= 2'h0;
            setQ <= 2'h0;
        end else if (wrTake) begin
            setQ <= 2'h0;
            if (address == sadc_pkg::CFG_OFS) cfgQ <= cfgNew;
            if (address == sadc_pkg::CTRL_OFS && byteenable[0]) ctrlQ <= writedata[3:0];
            if (address == sadc_pkg::MASK_OFS && byteenable[0]) maskQ <= writedata[1:0];
        end else if (!settled) begin
            setQ <= setQ + 2'h1;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) highQ <= 8'h0;
        else highQ <= samplePulse ? highQ + 8'h1 : 8'h0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_req;
        (read || write) && waitrequest;
    endsequence
    sequence s_ack;
        !waitrequest ##1 waitrequest;
    endsequence
    property p_ack;
        s_req |=> s_ack;
    endproperty
    property p_unmapped;
        read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0;
    endproperty
    property p_ext_ref;
        settled && cfgQ[6] |-> refSel == 5'h01;
    endproperty
    property p_int_ref;
        settled && !cfgQ[6] |-> refSel == refExp;
    endproperty
    property p_chan;
        settled |-> chanConnect == chanExp;
    endproperty
    property p_power;
        settled |-> adcPowerOn == ctrlQ[0];
    endproperty
    property p_irq_off;
        settled && (!ctrlQ[2] || maskQ == 2'h0) |-> !irq;
    endproperty
    property p_sample_len;
        $fell(samplePulse) && cfgQ[1:0] == 2'h2 |-> highQ == (8'h1 << cfgQ[3:2]);
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late or long");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_ext_ref: assert property (p_ext_ref) else $error("external reference wrong");
    a_int_ref: assert property (p_int_ref) else $error("internal reference wrong");
    a_chan: assert property (p_chan) else $error("channel routing wrong");
    a_power: assert property (p_power) else $error("power enable wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    a_sample_len: assert property (p_sample_len) else $error("sample width wrong");
endmodule
bind sadc_control sadc_control_props u_props (.clock, .arst_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .irq, .samplePulse, .adcPowerOn,
    .refSel, .chanConnect);

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clock, arst_n, read, write, waitrequest, irq, cmpOut, samplePulse, adcPowerOn;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, q;
    logic [11:0] dacCode, level;
    logic [4:0] refSel;
    logic [13:0] chanConnect;
    logic [7:0] analogPinA, analogPinB;
    int error_cnt = 0, cmp_count = 0, cycles = 0;
    sadc_control dut (.clock, .arst_n, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .irq, .cmpOut, .dacCode, .samplePulse, .adcPowerOn,
        .refSel, .chanConnect, .analogPinA, .analogPinB);
    sadc_core_model core (.chanConnect, .dacCode, .level, .cmpOut);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        check("busAnswer", n < 50, 1);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic t_route();
        logic [31:0] v;
        logic [7:0] pa;
        for (int c = 0; c < 17; c++) begin
            pa = 8'(c * 19);
            v = {~pa, pa, 4'(c), 2'h0, c < 16, 2'(c), c[2], 6'h00};
            bus(0, sadc_pkg::CFG_OFS, v);
            bus(1, sadc_pkg::CFG_OFS, 32'h0);
            check("cfg", q, v);
            check("refSel", refSel, c[2] ? 5'h01 : 5'h02 << (3 - c % 4));
            check("chanConnect", chanConnect, (c < 13) ? 1 << c : 0);
            check("analogPins", {analogPinB, analogPinA}, {~pa, pa});
        end
    endtask
    task automatic t_conv(input logic [1:0] res, sh, dv, input logic [11:0] lvl);
        int dn, nb, sl, w = 0, t = 0;
        dn = dv == 0 ? 16 : dv == 1 ? 8 : dv == 2 ? 1 : 2;
        nb = res[1] ? 12 : res[0] ? 10 : 8;
        sl = 1 << sh;
        level <= lvl;
        bus(0, sadc_pkg::CFG_OFS, {16'h0001, 4'h0, 3'h1, 3'h6, res, sh, dv});
        bus(0, sadc_pkg::CTRL_OFS, 32'hF);
        while (samplePulse !== 1'b1 && t < 100) begin
            @(posedge clock);
            t++;
        end
        while (samplePulse === 1'b1 && w < 300) begin
            @(posedge clock);
            w++;
        end
        check("sampleWidth", w, sl * dn);
        t = w;
        while (irq !== 1'b1 && t < 800) begin
            @(posedge clock);
            t++;
        end
        check("convTime", t >= (sl + nb + 1) * dn && t <= (sl + nb + 3) * dn + 4, 1);
        bus(1, sadc_pkg::STAT_OFS, 32'h0);
        check("done", q[2], 1);
        check("result", q[27:16], lvl & (12'hFFF << (12 - nb)));
        bus(1, sadc_pkg::CTRL_OFS, 32'h0);
        check("startBit", q[1], 0);
        bus(0, sadc_pkg::STAT_OFS, 32'h3);
        bus(1, sadc_pkg::STAT_OFS, 32'h0);
        check("cleared", {q[1:0], irq}, 0);
    endtask
    task automatic t_irq();
        int r = 0;
        bus(0, sadc_pkg::CTRL_OFS, 32'hF);
        bus(0, sadc_pkg::CTRL_OFS, 32'hF);
        bus(1, sadc_pkg::STAT_OFS, 32'h0);
        check("busy", q[2], 0);
        do bus(1, sadc_pkg::STAT_OFS, 32'h0); while (q[2] !== 1'b1 && ++r < 200);
        r = 0;
        repeat (40) begin
            @(posedge clock);
            r += samplePulse;
        end
        check("noRestart", r, 0);
        check("irqRaised", irq, 1);
        bus(0, sadc_pkg::MASK_OFS, 32'h0);
        bus(1, sadc_pkg::STAT_OFS, 32'h0);
        check("masked", {q[0], irq}, 2'b10);
        bus(0, sadc_pkg::MASK_OFS, 32'h3);
        bus(1, sadc_pkg::STAT_OFS, 32'h0);
        check("unmasked", irq, 1);
    endtask
    initial begin
        arst_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hF;
        level = 12'h000;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        bus(1, sadc_pkg::CFG_OFS, 32'h0);
        check("cfgReset", q, sadc_pkg::CFG_RESET);
        check("refReset", refSel, 5'h10);
        // Only lane 1 enabled: config takes bits 15:8, control ignores the write
        byteenable <= 4'h2;
        bus(0, sadc_pkg::CFG_OFS, 32'hFFFFFFFF);
        bus(0, sadc_pkg::CTRL_OFS, 32'hF);
        byteenable <= 4'hF;
        bus(1, sadc_pkg::CFG_OFS, 32'h0);
        check("cfgLane", q, 32'h0000FF00);
        check("ctrlLane", adcPowerOn, 0);
        bus(0, 4'h2, 32'hFFFFFFFF);
        bus(1, 4'h2, 32'h0);
        check("unmapped", q, 0);
        bus(0, sadc_pkg::MASK_OFS, 32'h3);
        t_route();
        bus(0, sadc_pkg::CTRL_OFS, 32'h1);
        repeat (10240) @(posedge clock);
        check("powerOn", adcPowerOn, 1);
        t_conv(2'h0, 2'h0, 2'h2, 12'hFFF);
        t_conv(2'h1, 2'h1, 2'h3, 12'h5A5);
        t_conv(2'h2, 2'h2, 2'h1, 12'h123);
        t_conv(2'h3, 2'h3, 2'h0, 12'h800);
        t_irq();
        conclude();
    end
endmodule
